//--- shared/cfl_defs.svh
`ifndef CFL_DEFS_SVH
`define CFL_DEFS_SVH

`define CFL_OFS_ID_LOW 4'h0
`define CFL_OFS_SCRATCH 4'h4
`define CFL_OFS_BOARD 4'h8
`define CFL_OFS_ID_HIGH 4'hc
`define CFL_SCRATCH_RST 32'h00000000
`define CFL_BOARD_RST 32'h0e787fc0
`define CFL_ID_LOW_VAL 32'h5a5a0001
`define CFL_ID_HIGH_VAL 32'h5a5a0002
`define CFL_BIT_LOCAL_RST 0
`define CFL_BIT_BOARD_RST 1
`define CFL_BIT_RECONF_RST 2
`define CFL_SW_POS_LO 3
`define CFL_SW_POS_HI 5
`define CFL_SEL_LO 6
`define CFL_SEL_HI 8
`define CFL_BIT_OVERRIDE 9
`define CFL_BIT_OSC_SLOW 10
`define CFL_BIT_OSC_FAST 11
`define CFL_BIT_OSC_GATE 12
`define CFL_RW_MASK 32'h01ffffc0
`define CFL_PULSE_NS 200
`define CFL_PULSE_CYC ((`CFL_PULSE_NS + 7) / 8)
`define CFL_DCLK_DIV 4'h4
`define CFL_IMAGE_BYTES 24'h000100
`define CFL_PAGE_ADDR_BITS 21

`endif

//--- shared/cfl_pkg.sv
`default_nettype none
package cfl_pkg;
   typedef enum logic [3:0]
   {
      CFL_IDLE = 4'b0001,
      CFL_FETCH = 4'b0010,
      CFL_SHIFT = 4'b0100,
      CFL_DONE = 4'b1000
   } cfl_state_t;
endpackage
`default_nettype wire

//--- logic/cfl_serializer.sv
`timescale 1ns/1ns
`default_nettype none
`include "cfl_defs.svh"

module cfl_serializer
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic enable_i,
   input wire logic [2:0] page_i,
   input wire logic [7:0] flash_data_i,
   output logic [23:0] flash_addr_o,
   output logic flash_oe_n_o,
   output logic dclk_o,
   output logic data0_o,
   output logic done_o
);
   cfl_pkg::cfl_state_t state_r, state_nxt;
   logic [3:0] div_r, div_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [23:0] cnt_r, cnt_nxt;
   logic [2:0] page_r, page_nxt;
   logic dclk_r, dclk_nxt;
   logic tick;

   // -------------------------------------------------------------------------
   // Divided configuration clock and byte serializer.
   // -------------------------------------------------------------------------
   assign tick = (div_r == `CFL_DCLK_DIV - 4'h1);

   always_comb
   begin
      state_nxt = state_r;
      div_nxt = tick ? 4'h0 : div_r + 4'h1;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      page_nxt = page_r;
      dclk_nxt = dclk_r;
      unique case (state_r)
         cfl_pkg::CFL_IDLE:
         begin
            dclk_nxt = 1'b0;
            if (start_i && enable_i)
            begin
               state_nxt = cfl_pkg::CFL_FETCH;
               cnt_nxt = 24'h000000;
               page_nxt = page_i;
            end
         end
         cfl_pkg::CFL_FETCH:
         begin
            shift_nxt = flash_data_i;
            bit_nxt = 3'h0;
            state_nxt = cfl_pkg::CFL_SHIFT;
         end
         cfl_pkg::CFL_SHIFT:
         begin
            if (tick)
            begin
               dclk_nxt = ~dclk_r;
               if (dclk_r)
               begin
                  shift_nxt = {1'b0, shift_r[7:1]};
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7)
                  begin
                     cnt_nxt = cnt_r + 24'h000001;
                     state_nxt = (cnt_r == `CFL_IMAGE_BYTES - 24'h000001) ? cfl_pkg::CFL_DONE
                                                                        : cfl_pkg::CFL_FETCH;
                  end
               end
            end
         end
         cfl_pkg::CFL_DONE:
         begin
            dclk_nxt = 1'b0;
         end
      endcase
      if (!enable_i)
      begin
         state_nxt = cfl_pkg::CFL_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= cfl_pkg::CFL_IDLE;
         div_r <= 4'h0;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         cnt_r <= 24'h000000;
         page_r <= 3'h0;
         dclk_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         page_r <= page_nxt;
         dclk_r <= dclk_nxt;
      end
   end

   // The top registers address and enable once more, so they are taken from the next state.
   // That way the flash byte is already on the bus during the fetch cycle that samples it.
   assign flash_addr_o = {page_nxt, cnt_nxt[`CFL_PAGE_ADDR_BITS-1:0]};
   assign flash_oe_n_o = (state_nxt == cfl_pkg::CFL_IDLE) || (state_nxt == cfl_pkg::CFL_DONE);
   assign dclk_o = dclk_r;
   assign data0_o = shift_r[0];
   assign done_o = (state_r == cfl_pkg::CFL_DONE);

   cfl_sync_cover_a: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == cfl_pkg::CFL_SHIFT ##1 state_r == cfl_pkg::CFL_FETCH);
endmodule
`default_nettype wire

//--- logic/cfl_top.sv
// Summary of operation
// - Four 32-bit registers at 0x0, 0x4, 0x8, 0xC.
// - Buttons restore all register defaults.
// - Board control word resets to 0x0e787fc0.
// - Bit 0 zero pulses local reset only.
// - Bit 1 zero pulses local and board reset.
// - Bit 2 resets and reloads the FPGA.
// - Bits 5:3 show live rotary switch.
// - Bits 8:6 hold software image page.
// - Bit 9 picks software or switch page.
// - Bit 10 enables slow oscillator, gated.
// - Bit 11 enables fast oscillator, gated.
// - Bit 12 one forces both oscillator enables.
// - Configure only while enable switch reads one.
// - Flash bytes shifted out serially to FPGA.
// - Generate configuration clock and flash addressing.
`timescale 1ns/1ns
`default_nettype none
`include "cfl_defs.svh"

module cfl_top
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic board_reset_btn_n_i,
   input wire logic config_btn_a_n_i,
   input wire logic config_btn_b_n_i,
   input wire logic [2:0] image_rotary_switch_i,
   input wire logic controller_enable_switch_i,
   input wire logic [7:0] flash_data_i,
   output logic [23:0] flash_addr_o,
   output logic flash_oe_n_o,
   output logic dclk_o,
   output logic data0_o,
   output logic config_done_o,
   output logic board_reset_n_o,
   output logic board_reset_oe_n_o,
   output logic osc_slow_en_o,
   output logic osc_fast_en_o
);
   // -------------------------------------------------------------------------
   // Reset release and button reset.
   // -------------------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic btn_any;
   logic local_rst_n;

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_sync_r <= 2'b00;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];
   assign btn_any = !board_reset_btn_n_i || !config_btn_a_n_i || !config_btn_b_n_i;

   // -------------------------------------------------------------------------
   // Register file and APB slave.
   // -------------------------------------------------------------------------
   logic [31:0] scratch_r, scratch_nxt;
   logic [31:0] board_r, board_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [7:0] pulse_cnt_r, pulse_cnt_nxt;
   logic board_pulse_r, board_pulse_nxt;
   logic reconf_req_r, reconf_req_nxt;
   logic osc_slow_r, osc_slow_nxt;
   logic osc_fast_r, osc_fast_nxt;
   logic bdr_n_r, bdr_n_nxt;
   logic access;
   logic wr_board;
   logic [3:0] ofs;
   logic [31:0] live_board;
   logic mapped;

   assign access = psel && penable && !pready_r;
   assign ofs = paddr[3:0];
   assign mapped = (paddr[31:4] == 28'h0000000) && (ofs[1:0] == 2'b00);
   assign wr_board = access && pwrite && mapped && (ofs == `CFL_OFS_BOARD);
   assign live_board = {board_r[31:6], image_rotary_switch_i, 3'h0};

   always_comb
   begin
      scratch_nxt = scratch_r;
      board_nxt = board_r;
      prdata_nxt = prdata_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      pulse_cnt_nxt = (pulse_cnt_r != 8'h00) ? pulse_cnt_r - 8'h01 : 8'h00;
      board_pulse_nxt = board_pulse_r && (pulse_cnt_r != 8'h00);
      reconf_req_nxt = 1'b0;
      if (access)
      begin
         pready_nxt = 1'b1;
         pslverr_nxt = !mapped;
         if (pwrite && mapped)
         begin
            if (ofs == `CFL_OFS_SCRATCH)
            begin
               scratch_nxt = pwdata;
            end
            if (ofs == `CFL_OFS_BOARD)
            begin
               board_nxt = (board_r & ~`CFL_RW_MASK) | (pwdata & `CFL_RW_MASK);
            end
         end
         else if (mapped)
         begin
            unique case (ofs)
               `CFL_OFS_ID_LOW: prdata_nxt = `CFL_ID_LOW_VAL;
               `CFL_OFS_SCRATCH: prdata_nxt = scratch_r;
               `CFL_OFS_BOARD: prdata_nxt = live_board;
               default: prdata_nxt = `CFL_ID_HIGH_VAL;
            endcase
         end
         else
         begin
            prdata_nxt = 32'h00000000;
         end
      end
      if (wr_board && !pwdata[`CFL_BIT_LOCAL_RST])
      begin
         pulse_cnt_nxt = 8'(`CFL_PULSE_CYC);
      end
      if (wr_board && !pwdata[`CFL_BIT_BOARD_RST])
      begin
         pulse_cnt_nxt = 8'(`CFL_PULSE_CYC);
         board_pulse_nxt = 1'b1;
      end
      if (wr_board && !pwdata[`CFL_BIT_RECONF_RST])
      begin
         pulse_cnt_nxt = 8'(`CFL_PULSE_CYC);
         reconf_req_nxt = 1'b1;
      end
      osc_slow_nxt = board_r[`CFL_BIT_OSC_GATE] || board_r[`CFL_BIT_OSC_SLOW];
      osc_fast_nxt = board_r[`CFL_BIT_OSC_GATE] || board_r[`CFL_BIT_OSC_FAST];
      bdr_n_nxt = !(board_pulse_nxt);
   end

   // Reconfigure request survives the local pulse, which would otherwise swallow it.
   logic reconf_pend_r, reconf_pend_nxt;
   logic [2:0] page_sel;
   logic ser_start;
   assign page_sel = board_r[`CFL_BIT_OVERRIDE] ? image_rotary_switch_i
                                                : board_r[`CFL_SEL_HI:`CFL_SEL_LO];
   assign ser_start = reconf_pend_r && (pulse_cnt_r == 8'h00);
   assign local_rst_n = rst_n && (pulse_cnt_r == 8'h00);

   always_comb
   begin
      reconf_pend_nxt = reconf_pend_r;
      if (reconf_req_r)
      begin
         reconf_pend_nxt = 1'b1;
      end
      else if (ser_start)
      begin
         reconf_pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scratch_r <= `CFL_SCRATCH_RST;
         board_r <= `CFL_BOARD_RST;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         pulse_cnt_r <= 8'h00;
         board_pulse_r <= 1'b0;
         reconf_req_r <= 1'b0;
         reconf_pend_r <= 1'b1;
         osc_slow_r <= 1'b1;
         osc_fast_r <= 1'b1;
         bdr_n_r <= 1'b1;
      end
      else if (btn_any)
      begin
         scratch_r <= `CFL_SCRATCH_RST;
         board_r <= `CFL_BOARD_RST;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         pulse_cnt_r <= 8'h00;
         board_pulse_r <= 1'b0;
         reconf_req_r <= 1'b0;
         reconf_pend_r <= 1'b1;
         osc_slow_r <= 1'b1;
         osc_fast_r <= 1'b1;
         bdr_n_r <= 1'b1;
      end
      else
      begin
         scratch_r <= scratch_nxt;
         board_r <= board_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         board_pulse_r <= board_pulse_nxt;
         reconf_req_r <= reconf_req_nxt;
         reconf_pend_r <= reconf_pend_nxt;
         osc_slow_r <= osc_slow_nxt;
         osc_fast_r <= osc_fast_nxt;
         bdr_n_r <= bdr_n_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign board_reset_n_o = bdr_n_r;
   assign board_reset_oe_n_o = bdr_n_r;
   assign osc_slow_en_o = osc_slow_r;
   assign osc_fast_en_o = osc_fast_r;

   // -------------------------------------------------------------------------
   // Flash loading engine, held in reset by the local pulse.
   // -------------------------------------------------------------------------
   logic [23:0] ser_addr;
   logic ser_oe_n, ser_dclk, ser_data, ser_done;
   logic [23:0] faddr_r;
   logic foe_n_r, dclk_r, data_r, done_r;

   cfl_serializer u_ser
   (
      .core_clk_i(core_clk_i),
      .rst_n_i(local_rst_n),
      .start_i(ser_start),
      .enable_i(controller_enable_switch_i),
      .page_i(page_sel),
      .flash_data_i(flash_data_i),
      .flash_addr_o(ser_addr),
      .flash_oe_n_o(ser_oe_n),
      .dclk_o(ser_dclk),
      .data0_o(ser_data),
      .done_o(ser_done)
   );

   // Registered again so every pin leaves from a flop; the extra cycle is harmless to the divided clock.
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         faddr_r <= 24'h000000;
         foe_n_r <= 1'b1;
         dclk_r <= 1'b0;
         data_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         faddr_r <= ser_addr;
         foe_n_r <= ser_oe_n;
         dclk_r <= ser_dclk;
         data_r <= ser_data;
         done_r <= ser_done;
      end
   end
   assign flash_addr_o = faddr_r;
   assign flash_oe_n_o = foe_n_r;
   assign dclk_o = dclk_r;
   assign data0_o = data_r;
   assign config_done_o = done_r;

   // -------------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------------
   osc_gate_force_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      $past(board_r[`CFL_BIT_OSC_GATE]) && !$past(btn_any) |-> osc_slow_r && osc_fast_r)
      else $error("Gate bit did not force oscillators on.");
   osc_slow_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      !$past(board_r[`CFL_BIT_OSC_GATE]) && !$past(btn_any) |-> osc_slow_r == $past(board_r[`CFL_BIT_OSC_SLOW]))
      else $error("Slow oscillator enable mismatch.");
   osc_fast_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      !$past(board_r[`CFL_BIT_OSC_GATE]) && !$past(btn_any) |-> osc_fast_r == $past(board_r[`CFL_BIT_OSC_FAST]))
      else $error("Fast oscillator enable mismatch.");
   board_pulse_out_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      wr_board && !pwdata[`CFL_BIT_BOARD_RST] |-> ##2 !board_reset_n_o && !local_rst_n)
      else $error("Board reset pulse missing.");
   local_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      wr_board && !pwdata[`CFL_BIT_LOCAL_RST] && pwdata[`CFL_BIT_BOARD_RST] && !board_pulse_r
      |-> ##1 !local_rst_n ##1 board_reset_n_o)
      else $error("Local reset pulse wrong.");
   reconf_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      wr_board && !pwdata[`CFL_BIT_RECONF_RST] |-> ##[1:40] ser_start)
      else $error("Reconfiguration did not start.");
   id_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      access && !pwrite && paddr == 32'h00000000 |=> prdata == `CFL_ID_LOW_VAL)
      else $error("Identity word wrong.");
   switch_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || btn_any)
      access && !pwrite && paddr == 32'h00000008 |=> prdata[5:3] == $past(image_rotary_switch_i))
      else $error("Switch field not live.");
   button_default_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      btn_any |=> board_r == `CFL_BOARD_RST && scratch_r == `CFL_SCRATCH_RST)
      else $error("Button did not restore defaults.");
   page_pick_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !board_r[`CFL_BIT_OVERRIDE] |-> page_sel == board_r[8:6])
      else $error("Software page not selected.");
   disable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !controller_enable_switch_i [*3] |-> flash_oe_n_o)
      else $error("Loader ran while disabled.");

   wr_board_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) wr_board);
   reconf_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) ser_start);
   done_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) config_done_o);
endmodule
`default_nettype wire

//--- verification/cfl_flash_model.sv
`timescale 1ns/1ns
`default_nettype none

module cfl_flash_model
(
   input wire logic core_clk_i,
   input wire logic [23:0] flash_addr_i,
   input wire logic flash_oe_n_i,
   output logic [7:0] flash_data_o
);
   // ----------------
   // Flash array
   // ----------------
   // Content mixes page and byte index, so a wrong address shows up as wrong data.
   logic [7:0] cell_val;
   logic [7:0] last_r = 8'h00;
   assign cell_val = flash_addr_i[7:0] ^ {flash_addr_i[23:21], flash_addr_i[12:8]} ^ 8'h3c;
   // A deselected flash floats, so the bus shows the inverse of the last byte, never a lucky value.
   assign flash_data_o = flash_oe_n_i ? ~last_r : cell_val;
   always_ff @(posedge core_clk_i)
   begin
      if (!flash_oe_n_i)
      begin
         last_r <= cell_val;
      end
   end
endmodule

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cfl_defs.svh"

module tb_top;
   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] btn_n = 3'h7;
   logic [2:0] sw = 3'h5;
   logic en_sw = 1'b1;
   logic [7:0] fdata;
   logic [23:0] faddr;
   logic foe_n, dclk_o, data0_o, done_o, brst_n, brst_oe_n, osc_slow, osc_fast;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;

   always #4 core_clk_i = ~core_clk_i;

   cfl_top u_dut
   (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .board_reset_btn_n_i(btn_n[0]), .config_btn_a_n_i(btn_n[1]), .config_btn_b_n_i(btn_n[2]),
      .image_rotary_switch_i(sw), .controller_enable_switch_i(en_sw), .flash_data_i(fdata),
      .flash_addr_o(faddr), .flash_oe_n_o(foe_n), .dclk_o(dclk_o), .data0_o(data0_o),
      .config_done_o(done_o), .board_reset_n_o(brst_n), .board_reset_oe_n_o(brst_oe_n),
      .osc_slow_en_o(osc_slow), .osc_fast_en_o(osc_fast)
   );

   cfl_flash_model u_flash
   (
      .core_clk_i(core_clk_i), .flash_addr_i(faddr), .flash_oe_n_i(foe_n), .flash_data_o(fdata)
   );

   // ----------------
   // Shared tasks
   // ----------------
   task automatic end_of_test();
      $display("err_count=%0d checks_done=%0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
         err_count++;
      end
   endtask

   task automatic clocks(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   // Every access is a whole word; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge core_clk_i);
      q = prdata;
      e = pslverr;
      cmp(32'(pready), 32'h1, "pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      cmp(32'(e), 32'h0, "rd pslverr");
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      cmp(32'(e), 32'h0, "wr pslverr");
   endtask

   // Reset bits read back as zero, so they are forced to one unless a pulse is wanted.
   task automatic board_rmw(input logic [31:0] clr, input logic [31:0] set);
      logic [31:0] q;
      rd(32'h8, q);
      wr(32'h8, ((q | 32'h7) & ~clr) | set);
   endtask

   function automatic logic [7:0] exp_byte(input logic [2:0] p, input int i);
      return 8'(i) ^ {p, 5'h0} ^ 8'h3c;
   endfunction

   task automatic load_check(input logic [2:0] page);
      int n;
      int b;
      logic [7:0] sh;
      logic prev;
      for (n = 0; n < 2000 && foe_n !== 1'b0; n++) @(posedge core_clk_i);
      cmp(32'(foe_n), 32'h0, "loader start");
      cmp(32'(faddr[23:21]), 32'(page), "page");
      prev = dclk_o;
      b = 0;
      while (b < `CFL_IMAGE_BYTES * 8 && n < 40000)
      begin
         @(posedge core_clk_i);
         n++;
         if (dclk_o === 1'b1 && prev === 1'b0)
         begin
            sh = {data0_o, sh[7:1]};
            b++;
            if (b % 8 == 0) cmp(32'(sh), 32'(exp_byte(page, b / 8 - 1)), "serial byte");
         end
         prev = dclk_o;
      end
      for (n = 0; n < 200 && done_o !== 1'b1; n++) @(posedge core_clk_i);
      cmp(32'(done_o), 32'h1, "done");
      n = 0;
      repeat (64)
      begin
         @(posedge core_clk_i);
         if (dclk_o !== 1'b0 || foe_n !== 1'b1) n++;
      end
      cmp(n, 0, "idle after image");
   endtask

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      rd(32'h0, q);
      cmp(q, `CFL_ID_LOW_VAL, "id low");
      rd(32'h4, q);
      cmp(q, `CFL_SCRATCH_RST, "scratch rst");
      for (int i = 0; i < 2; i++)
      begin
         sw <= i ? 3'h2 : 3'h5;
         clocks(3);
         rd(32'h8, q);
         cmp(q, (`CFL_BOARD_RST & ~32'h3f) | 32'({sw, 3'h0}), "board rst");
      end
      sw <= 3'h5;
      wr(32'h0, 32'hffffffff);
      wr(32'hc, 32'h0);
      rd(32'h0, q);
      cmp(q, `CFL_ID_LOW_VAL, "id low kept");
      rd(32'hc, q);
      cmp(q, `CFL_ID_HIGH_VAL, "id high kept");
      wr(32'h4, 32'ha55a3cc3);
      rd(32'h4, q);
      cmp(q, 32'ha55a3cc3, "scratch");
      apb(1'b0, 32'h10, 32'h0, q, e);
      cmp(32'(e), 32'h1, "unmapped");
   endtask

   task automatic t_osc();
      // The fast oscillator clocks the register side, so it is never switched off here.
      for (int k = 2; k < 8; k++)
      begin
         board_rmw(32'h1c00, 32'(k) << 10);
         clocks(3);
         cmp(32'({osc_fast, osc_slow}), k[2] ? 32'h3 : 32'(k[1:0]), "osc");
      end
   endtask

   task automatic t_pulse();
      int lo;
      int bad;
      for (int k = 0; k < 3; k++)
      begin
         board_rmw(k == 2 ? 32'h0 : 32'(k + 1), 32'h0);
         lo = 0;
         bad = 0;
         repeat (80)
         begin
            @(posedge core_clk_i);
            if (brst_n === 1'b0) lo++;
            if (brst_oe_n !== brst_n) bad++;
         end
         cmp(bad, 0, "oe follows level");
         cmp(32'(k == 1 ? (lo > 0 && lo <= 2 * `CFL_PULSE_CYC) : lo == 0), 32'h1, "board pulse");
      end
   endtask

   task automatic t_dis();
      int n;
      en_sw <= 1'b0;
      clocks(4);
      board_rmw(32'h4, 32'h0);
      n = 0;
      repeat (300)
      begin
         @(posedge core_clk_i);
         if (foe_n !== 1'b1 || dclk_o !== 1'b0) n++;
      end
      cmp(n, 0, "disabled loader idle");
      en_sw <= 1'b1;
      clocks(4);
   endtask

   task automatic t_reload();
      board_rmw(32'h3c0, 32'h80);
      board_rmw(32'h4, 32'h0);
      load_check(3'h2);
   endtask

   task automatic t_btn();
      logic [31:0] q;
      for (int i = 0; i < 3; i++)
      begin
         wr(32'h4, 32'h00001234);
         board_rmw(32'h1c0, 32'h0);
         btn_n <= ~(3'h1 << i);
         clocks(2);
         btn_n <= 3'h7;
         clocks(2);
         rd(32'h4, q);
         cmp(q, `CFL_SCRATCH_RST, "button scratch");
         rd(32'h8, q);
         cmp(q, (`CFL_BOARD_RST & ~32'h3f) | 32'h28, "button board");
      end
   endtask

   // ----------------
   // Sequence
   // ----------------
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_count++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (20) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      load_check(3'h5);
      t_regs();
      t_osc();
      t_pulse();
      t_dis();
      t_reload();
      t_btn();
      end_of_test();
   end
endmodule

`default_nettype wire
